// File: verilog/hbgc_pkg.sv
// Package of constants for the H-bridge gate control logic
`default_nettype none
package hbgc_pkg;
  // Clock rate in MHz and current-limit off-time in ns
  localparam int unsigned HBGC_CLK_MHZ = 200;
  localparam int unsigned HBGC_OFF_TIME_NS = 20000;
  // Off-time in clock cycles, rounded down (longest figure)
  localparam int unsigned HBGC_OFF_CYCLES =
    (HBGC_OFF_TIME_NS * HBGC_CLK_MHZ) / 1000;
  // Reset values of the registered outputs
  localparam logic HBGC_FLAG_RST = 1'b1;
  localparam logic HBGC_DRV_RST = 1'b0;
  // Bridge control states, one-hot
  typedef enum logic [3:0] {
    HBGC_SLEEP = 4'h1,
    HBGC_RUN = 4'h2,
    HBGC_LIMIT = 4'h4,
    HBGC_LATCH = 4'h8
  } hbgc_state_t;
endpackage
`default_nettype wire

// File: verilog/hbgc_gate_control.sv
// Gate control and protection logic of a motor H-bridge
//
// What this block does
// - Disable inputs clear latched tri-state conditions and restore the flag.
// - Undervoltage while awake tri-states both outputs and pulls flag low.
// - Undervoltage end restores flag and outputs without any host toggle.
// - Short circuit latches outputs off and flag low, ignoring phase inputs.
// - Disable A falling or disable B rising clears a latched fault.
// - Enable toggle or supply removal also clears a latched fault.
// - After clearing, outputs follow current inputs unless still overheated.
// - Current-limit trip tri-states outputs for a fixed off-time.
// - Above 160 C the current limit threshold drops to the reduced one.
// - Overtemperature trip latches outputs off and flag low.
// - Fault reset re-enables outputs only below trip minus hysteresis.
// - Power cycle returns the device from any latched fault.
// - Normal operation drives output A from phase A, B from phase B.
// - Any asserted disable tri-states both outputs; logic keeps running.
// - Low or floating enable means sleep with both outputs tri-stated.
`default_nettype none
module hbgc_gate_control
  import hbgc_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = HBGC_OFF_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host control pins (already resolved to default level when floating)
  input wire logic enable_in,
  input wire logic phase_in_a_in,
  input wire logic phase_in_b_in,
  input wire logic disable_a_active_high_in,
  input wire logic disable_b_active_low_in,
  // Analog sense indications
  input wire logic supply_rail_ok_in,
  input wire logic undervoltage_in,
  input wire logic short_circuit_in,
  input wire logic current_limit_hit_in,
  input wire logic temp_above_foldback_in,
  input wire logic overtemp_trip_point_in,
  input wire logic temp_below_hyst_in,
  // Bridge drive: level and output enable per half-bridge
  output logic bridge_out_a_out,
  output logic bridge_out_a_oe_out,
  output logic bridge_out_b_out,
  output logic bridge_out_b_oe_out,
  // Reduced current limit select and open-drain fault flag
  output logic current_limit_reduced_out,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe_out
);

  localparam int CNT_W = $clog2(OFF_CYCLES + 1);

  // Two-flop synchronisers for every pin and sense input
  // Every input is asynchronous to clk_in, the sense flags included
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s1_d;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s2_d;

  assign raw_in = {temp_below_hyst_in, overtemp_trip_point_in,
                   temp_above_foldback_in, current_limit_hit_in,
                   short_circuit_in, undervoltage_in, supply_rail_ok_in,
                   disable_b_active_low_in, disable_a_active_high_in,
                   phase_in_b_in, phase_in_a_in, enable_in};

  // Synchroniser next values
  always_comb begin
    s1_d = raw_in;
    s2_d = s1_q;
  end

  // Synchroniser registers; reset values match the floating defaults.
  // Undervoltage reads as present until real samples arrive, so nothing
  // can drive while the chain fills after power-up.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= 12'h04E;
      s2_q <= 12'h04E;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Named views of the synchronised inputs
  logic en_s;
  logic ph_a_s;
  logic ph_b_s;
  logic dis_a_s;
  logic dis_b_n_s;
  logic rail_s;
  logic uv_s;
  logic short_s;
  logic current_limit_threshold_s;
  logic fold_s;
  logic otp_s;
  logic cool_s;
  assign {cool_s, otp_s, fold_s, current_limit_threshold_s, short_s, uv_s, rail_s,
          dis_b_n_s, dis_a_s, ph_b_s, ph_a_s, en_s} = s2_q;

  // Previous values for edge detection on the clearing inputs
  logic dis_a_prev_q;
  logic dis_a_prev_d;
  logic dis_b_prev_q;
  logic dis_b_prev_d;
  logic en_prev_q;
  logic en_prev_d;
  logic rail_prev_q;
  logic rail_prev_d;

  // Main state and latched-fault bookkeeping
  hbgc_state_t state_q;
  hbgc_state_t state_d;
  logic ot_latched_q;
  logic ot_latched_d;
  logic [CNT_W-1:0] off_cnt_q;
  logic [CNT_W-1:0] off_cnt_d;
  logic a_q;
  logic a_d;
  logic a_oe_q;
  logic a_oe_d;
  logic b_q;
  logic b_d;
  logic b_oe_q;
  logic b_oe_d;
  logic flag_oe_q;
  logic flag_oe_d;
  logic reduced_q;
  logic reduced_d;
  logic flag_lvl_q;
  logic flag_lvl_d;

  logic disabled;
  logic clear_req;
  logic fault_now;

  // Edge helpers shared by every clearing input; a clear acts on the
  // transition only, so a pin parked at its clearing level does nothing
  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // A disable pin counts as asserted when either is set
  assign disabled = dis_a_s | ~dis_b_n_s;
  // Edges that clear a latched fault
  assign clear_req = fell(dis_a_prev_q, dis_a_s)
                   | rose(dis_b_prev_q, dis_b_n_s)
                   | fell(en_prev_q, en_s)
                   | rose(en_prev_q, en_s)
                   | rose(rail_prev_q, rail_s);
  assign fault_now = short_s | otp_s;

  // SLEEP: enable or supply low, bridge tri-stated and flag released.
  // RUN: bridge follows the phase pins unless disabled or undervoltage.
  // LIMIT: fixed off-time after a current-limit trip, then RUN again.
  // LATCH: short or overtemperature held until a clearing edge.
  // Next-state logic of the controller
  always_comb begin
    dis_a_prev_d = dis_a_s;
    dis_b_prev_d = dis_b_n_s;
    en_prev_d = en_s;
    rail_prev_d = rail_s;
    state_d = state_q;
    ot_latched_d = ot_latched_q;
    off_cnt_d = off_cnt_q;
    case (state_q)
      HBGC_SLEEP: begin
        // Sleeping clears nothing latched by itself; the enable edge does.
        // A fault already present on wake with no undervoltage latches at once, so the bridge
        // never drives for a cycle into a short or an overheated die.
        if (en_s && rail_s && fault_now && !uv_s) begin
          state_d = HBGC_LATCH;
          ot_latched_d = otp_s;
        end else if (en_s && rail_s) begin
          state_d = HBGC_RUN;
        end
      end
      HBGC_RUN: begin
        if (!en_s || !rail_s) begin
          state_d = HBGC_SLEEP;
        end else if (fault_now && !uv_s) begin
          state_d = HBGC_LATCH;
          ot_latched_d = otp_s;
        end else if (current_limit_threshold_s && !uv_s && !disabled) begin
          state_d = HBGC_LIMIT;
          off_cnt_d = CNT_W'(OFF_CYCLES);
        end
      end
      HBGC_LIMIT: begin
        // Fixed off-time; a short still latches during it. The count is
        // in clock cycles, so a different clock rate needs a new
        // OFF_CYCLES to keep the same time.
        if (!en_s || !rail_s) begin
          state_d = HBGC_SLEEP;
        end else if (fault_now) begin
          state_d = HBGC_LATCH;
          ot_latched_d = otp_s;
        end else if (off_cnt_q <= CNT_W'(1)) begin
          state_d = HBGC_RUN;
          off_cnt_d = '0;
        end else begin
          off_cnt_d = off_cnt_q - CNT_W'(1);
        end
      end
      HBGC_LATCH: begin
        if (!rail_s) begin
          state_d = HBGC_SLEEP;
          ot_latched_d = 1'b0;
        end else if (otp_s) begin
          ot_latched_d = 1'b1;
        end else if (clear_req && (!ot_latched_q || cool_s)) begin
          // An overtemperature latch re-enables only once cooled below the hysteresis point
          state_d = en_s ? HBGC_RUN : HBGC_SLEEP;
          ot_latched_d = 1'b0;
        end
      end
      default: begin
        state_d = HBGC_SLEEP;
      end
    endcase
  end

  // Output decode: drive only in run state with no disable or undervoltage.
  // Neither undervoltage nor a disable is latched, so drive returns by
  // itself three cycles after either goes away.
  always_comb begin
    a_d = HBGC_DRV_RST;
    b_d = HBGC_DRV_RST;
    a_oe_d = 1'b0;
    b_oe_d = 1'b0;
    flag_oe_d = 1'b0;
    reduced_d = fold_s;
    // Open-drain level never changes; registered so the pin leaves a flop
    flag_lvl_d = ~HBGC_FLAG_RST;
    if (state_d == HBGC_LATCH) begin
      // A fault held through sleep stays hidden until enable returns
      flag_oe_d = en_s;
    end else if (state_d != HBGC_SLEEP) begin
      if (uv_s || disabled) begin
        flag_oe_d = 1'b1;
      end else if (state_d == HBGC_RUN) begin
        a_d = ph_a_s;
        b_d = ph_b_s;
        a_oe_d = 1'b1;
        b_oe_d = 1'b1;
      end
    end
  end

  // Controller and output registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dis_a_prev_q <= 1'b1;
      dis_b_prev_q <= 1'b0;
      en_prev_q <= 1'b0;
      rail_prev_q <= 1'b0;
      state_q <= HBGC_SLEEP;
      ot_latched_q <= 1'b0;
      off_cnt_q <= '0;
      a_q <= HBGC_DRV_RST;
      b_q <= HBGC_DRV_RST;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
      flag_oe_q <= 1'b0;
      reduced_q <= 1'b0;
      flag_lvl_q <= ~HBGC_FLAG_RST;
    end else begin
      dis_a_prev_q <= dis_a_prev_d;
      dis_b_prev_q <= dis_b_prev_d;
      en_prev_q <= en_prev_d;
      rail_prev_q <= rail_prev_d;
      state_q <= state_d;
      ot_latched_q <= ot_latched_d;
      off_cnt_q <= off_cnt_d;
      a_q <= a_d;
      b_q <= b_d;
      a_oe_q <= a_oe_d;
      b_oe_q <= b_oe_d;
      flag_oe_q <= flag_oe_d;
      reduced_q <= reduced_d;
      flag_lvl_q <= flag_lvl_d;
    end
  end

  // Open-drain flag: level is always low, enable pulls the pin down
  assign bridge_out_a_out = a_q;
  assign bridge_out_a_oe_out = a_oe_q;
  assign bridge_out_b_out = b_q;
  assign bridge_out_b_oe_out = b_oe_q;
  assign current_limit_reduced_out = reduced_q;
  assign fault_flag_n_out = flag_lvl_q;
  assign fault_flag_n_oe_out = flag_oe_q;

endmodule
`default_nettype wire

// File: verif/hbgc_host_model.sv
// Host side pin model: drivers, pin default pulls and flag pull-up
`default_nettype none
module hbgc_host_model (
  // Pins {enable, phase a, phase b, disable a, disable b}
  input wire logic [4:0] drv_in,
  input wire logic [4:0] lvl_in,
  input wire logic flag_oe_in,
  input wire logic flag_lvl_in,
  // Resolved pin levels
  output logic [4:0] pin_out,
  output logic flag_pin_out
);
  // Undriven pins settle to their internal source or sink level
  assign pin_out = (drv_in & lvl_in) | (~drv_in & 5'h0E);
  // Open-drain flag rests high through the pull-up
  assign flag_pin_out = flag_oe_in ? flag_lvl_in : 1'b1;
endmodule
`default_nettype wire

// File: verif/hbgc_gate_props.sv
// Concurrent checks on the gate control ports
`default_nettype none
module hbgc_gate_props
  import hbgc_pkg::*;
#(parameter int unsigned OFF_CYCLES = HBGC_OFF_CYCLES) (
  // Clock, reset, host pins and sense inputs
  input wire logic clk_in, rst_n_in, enable_in, phase_in_a_in,
  input wire logic phase_in_b_in, disable_a_active_high_in,
  input wire logic disable_b_active_low_in, supply_rail_ok_in,
  input wire logic undervoltage_in, short_circuit_in,
  input wire logic current_limit_hit_in, temp_above_foldback_in,
  input wire logic overtemp_trip_point_in, temp_below_hyst_in,
  // Bridge, threshold and flag outputs
  input wire logic bridge_out_a_out, bridge_out_a_oe_out,
  input wire logic bridge_out_b_out, bridge_out_b_oe_out,
  input wire logic current_limit_reduced_out, fault_flag_n_out,
  input wire logic fault_flag_n_oe_out
);
  logic [2:0] age_q, age_d;
  // Checks wait until $past sees only values from after reset
  always_comb age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
  always_ff @(posedge clk_in) age_q <= rst_n_in ? age_d : 3'h0;
  wire logic rdy = (age_q == 3'h7);
  wire logic drv_any = bridge_out_a_oe_out | bridge_out_b_oe_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_awake;
    rdy && $past(enable_in, 3) && $past(supply_rail_ok_in, 3)
      && !$past(undervoltage_in, 3);
  endsequence
  sequence s_clear;
    $past(disable_a_active_high_in, 4) && !$past(disable_a_active_high_in, 3)
      && $past(disable_b_active_low_in, 3) && $past(temp_below_hyst_in, 3)
      && !$past(overtemp_trip_point_in, 3) && !$past(short_circuit_in, 3);
  endsequence
  a_sleep_quiet: assert property (
    rdy && !$past(enable_in, 3) |-> !drv_any && !fault_flag_n_oe_out)
    else $error("bridge driven or flag low in sleep");
  a_disable_off: assert property (
    s_awake ##0 ($past(disable_a_active_high_in, 3)
      || !$past(disable_b_active_low_in, 3))
    |-> !drv_any && fault_flag_n_oe_out)
    else $error("disabled bridge driven or flag high");
  a_uv_off: assert property (
    rdy && $past(enable_in, 3) && $past(supply_rail_ok_in, 3)
      && $past(undervoltage_in, 3) |-> !drv_any && fault_flag_n_oe_out)
    else $error("undervoltage not shown");
  a_phase_follow: assert property (
    rdy |-> (!bridge_out_a_oe_out
        || bridge_out_a_out == $past(phase_in_a_in, 3))
      && (!bridge_out_b_oe_out
        || bridge_out_b_out == $past(phase_in_b_in, 3)))
    else $error("bridge level differs from phase");
  a_short_latch: assert property (
    s_awake ##0 ($past(short_circuit_in, 3) && $past(bridge_out_a_oe_out))
    |-> !drv_any && fault_flag_n_oe_out)
    else $error("short did not latch off");
  a_hot_latch: assert property (
    s_awake ##0 $past(overtemp_trip_point_in, 3)
    |-> !drv_any && fault_flag_n_oe_out)
    else $error("overtemperature did not latch off");
  a_limit_off: assert property (
    s_awake ##0 ($past(current_limit_hit_in, 3) && $past(bridge_out_a_oe_out))
    |-> !drv_any)
    else $error("current limit did not tri-state");
  a_clear_flag: assert property (
    s_awake ##0 s_clear |-> !fault_flag_n_oe_out)
    else $error("clear edge left flag low");
  a_fold_select: assert property (
    s_awake |-> current_limit_reduced_out == $past(temp_above_foldback_in, 3))
    else $error("reduced limit select wrong");
endmodule
bind hbgc_gate_control hbgc_gate_props #(.OFF_CYCLES(OFF_CYCLES)) u_props (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .enable_in(enable_in),
  .phase_in_a_in(phase_in_a_in),
  .phase_in_b_in(phase_in_b_in),
  .disable_a_active_high_in(disable_a_active_high_in),
  .disable_b_active_low_in(disable_b_active_low_in),
  .supply_rail_ok_in(supply_rail_ok_in),
  .undervoltage_in(undervoltage_in),
  .short_circuit_in(short_circuit_in),
  .current_limit_hit_in(current_limit_hit_in),
  .temp_above_foldback_in(temp_above_foldback_in),
  .overtemp_trip_point_in(overtemp_trip_point_in),
  .temp_below_hyst_in(temp_below_hyst_in),
  .bridge_out_a_out(bridge_out_a_out),
  .bridge_out_a_oe_out(bridge_out_a_oe_out),
  .bridge_out_b_out(bridge_out_b_out),
  .bridge_out_b_oe_out(bridge_out_b_oe_out),
  .current_limit_reduced_out(current_limit_reduced_out),
  .fault_flag_n_out(fault_flag_n_out),
  .fault_flag_n_oe_out(fault_flag_n_oe_out)
);
`default_nettype wire

// File: verif/hbgc_gate_control_bench.sv
// Self-checking bench for the H-bridge gate control logic
`default_nettype none
module hbgc_gate_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  // Host pins {en, pa, pb, da, db}; sense {ok, uv, sc, lim, fold, ot, cool}
  logic [4:0] drv = 5'h00;
  logic [4:0] lvl = 5'h00;
  logic [6:0] sn = 7'h41;
  wire logic enable_in, phase_in_a_in, phase_in_b_in;
  wire logic disable_a_active_high_in, disable_b_active_low_in;
  logic supply_rail_ok_in, undervoltage_in, short_circuit_in;
  logic current_limit_hit_in, temp_above_foldback_in;
  logic overtemp_trip_point_in, temp_below_hyst_in;
  logic bridge_out_a_out, bridge_out_a_oe_out, bridge_out_b_out;
  logic bridge_out_b_oe_out, current_limit_reduced_out;
  logic fault_flag_n_out, fault_flag_n_oe_out, flag_pin;
  int n_errors = 0;
  int comparisons = 0;
  assign {supply_rail_ok_in, undervoltage_in, short_circuit_in,
    current_limit_hit_in, temp_above_foldback_in,
    overtemp_trip_point_in, temp_below_hyst_in} = sn;
  // Short off-time keeps the run brief
  hbgc_gate_control #(.OFF_CYCLES(8)) DUT (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(enable_in),
    .phase_in_a_in(phase_in_a_in),
    .phase_in_b_in(phase_in_b_in),
    .disable_a_active_high_in(disable_a_active_high_in),
    .disable_b_active_low_in(disable_b_active_low_in),
    .supply_rail_ok_in(supply_rail_ok_in),
    .undervoltage_in(undervoltage_in),
    .short_circuit_in(short_circuit_in),
    .current_limit_hit_in(current_limit_hit_in),
    .temp_above_foldback_in(temp_above_foldback_in),
    .overtemp_trip_point_in(overtemp_trip_point_in),
    .temp_below_hyst_in(temp_below_hyst_in),
    .bridge_out_a_out(bridge_out_a_out),
    .bridge_out_a_oe_out(bridge_out_a_oe_out),
    .bridge_out_b_out(bridge_out_b_out),
    .bridge_out_b_oe_out(bridge_out_b_oe_out),
    .current_limit_reduced_out(current_limit_reduced_out),
    .fault_flag_n_out(fault_flag_n_out),
    .fault_flag_n_oe_out(fault_flag_n_oe_out)
  );
  hbgc_host_model host (.drv_in(drv), .lvl_in(lvl),
    .flag_oe_in(fault_flag_n_oe_out), .flag_pin_out(flag_pin),
    .flag_lvl_in(fault_flag_n_out),
    .pin_out({enable_in, phase_in_a_in, phase_in_b_in,
      disable_a_active_high_in, disable_b_active_low_in}));
  always #2.5 clk_in = ~clk_in;
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Status {reduced, drive a, level a, drive b, level b, flag pin}
  task automatic ex(input string nm, input logic [5:0] e);
    w(3);
    chk(nm, {2'h0, e}, {2'h0, current_limit_reduced_out, bridge_out_a_oe_out,
      bridge_out_a_oe_out & bridge_out_a_out, bridge_out_b_oe_out,
      bridge_out_b_oe_out & bridge_out_b_out, flag_pin});
  endtask
  function automatic logic [5:0] run();
    return {2'h1, lvl[3], 1'b1, lvl[2], 1'b1};
  endfunction
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      lvl[3:2] = i[1:0];
      ex("phase mode", run());
    end
    lvl[1] = 1'b1;
    ex("disable a", 6'h00);
    lvl[1:0] = 2'h0;
    ex("disable b", 6'h00);
    drv = 5'h0C;
    ex("floating pins", 6'h01);
    drv = 5'h17;
    lvl = 5'h11;
    ex("floating phase a", 6'h1D);
    drv = 5'h1F;
    sn[5] = 1'b1;
    ex("undervoltage", 6'h00);
    sn[5] = 1'b0;
    ex("uv recovery", run());
    $display("levels test done");
  endtask
  task automatic t_latch();
    for (int k = 0; k < 6; k++) begin
      sn[k == 5 ? 1 : 4] = 1'b1;
      w(1);
      sn[4] = 1'b0;
      sn[1] = 1'b0;
      lvl[3] = ~lvl[3];
      ex("fault latch", 6'h00);
      case (k)
        0, 5: lvl[1] = 1'b1;
        1: lvl[0] = 1'b0;
        2: lvl[4] = 1'b0;
        3: sn[6] = 1'b0;
        default: rst_n_in = 1'b0;
      endcase
      w(4);
      lvl = {1'b1, lvl[3:2], 2'h1};
      sn[6] = 1'b1;
      rst_n_in = 1'b1;
      w(1);
      ex("cleared", run());
    end
    $display("latch test done");
  endtask
  task automatic t_temp();
    logic [7:0] n;
    n = 8'h00;
    sn[2] = 1'b1;
    ex("foldback", run() | 6'h20);
    sn[2:0] = 3'h2;
    ex("hot latch", 6'h00);
    sn[1] = 1'b0;
    lvl[1] = 1'b1;
    w(4);
    lvl[1] = 1'b0;
    ex("hot reset refused", 6'h00);
    sn[0] = 1'b1;
    lvl[1] = 1'b1;
    w(4);
    lvl[1] = 1'b0;
    ex("cool reset", run());
    sn[3] = 1'b1;
    w(1);
    sn[3] = 1'b0;
    w(2);
    while (bridge_out_a_oe_out !== 1'b1 && n < 8'h40) begin
      n++;
      w(1);
    end
    chk("off time", 8'h08, n);
    $display("temperature and limit test done");
  endtask
  initial begin
    w(20);
    rst_n_in = 1'b1;
    ex("sleep at start", 6'h01);
    drv = 5'h1F;
    lvl = 5'h11;
    t_levels();
    t_latch();
    t_temp();
    end_of_test();
  end
endmodule
`default_nettype wire
